// *** include/alu_pkg.sv ***
/*
 * Shared constants and types of the accumulator load unit: data widths,
 * stack depth, reset values, operation and operand codes, and the states
 * of the load sequencer.
 * Assumes a single 25 MHz clock and word and bit memories that answer
 * each request with a one-cycle acknowledge.
 */
package alu_pkg;
	localparam int ACC_W = 32;          // Accumulator and stack level width.
	localparam int WORD_W = 16;         // Width of one word-store location.
	localparam int ADDR_W = 16;         // Word and bit address width.
	localparam int STACK_DEPTH = 8;     // Levels of the accumulator stack.
	localparam int CNT_W = 6;           // Width of the bit count operand.
	localparam int OCT_DIGITS = 8;      // Octal digits taken from the operand.
	localparam logic [CNT_W-1:0] MAX_BITS = 6'h20;   // Longest bit field.
	localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;  // Cleared value.
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;     // Idle address.
	localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;    // Next location.
	localparam logic [CNT_W-1:0] CNT_RST = 6'h00;          // Counter start.
	localparam logic [CNT_W-1:0] CNT_STEP = 6'h01;         // Counter step.

	// Operations issued by the instruction sequencer.
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_DOUBLE_WORD_LOAD = 3'h1,
		OP_BIT_FIELD_LOAD = 3'h2,
		OP_OCTAL_ADDRESS_LOAD = 3'h3,
		OP_INDEXED_WORD_LOAD = 3'h4
	} alu_op_t;

	// Source kinds of the double-word load operand.
	typedef enum logic [1:0] {
		SRC_DIRECT = 2'h0,
		SRC_IMMEDIATE = 2'h1,
		SRC_POINTER = 2'h2
	} alu_src_t;

	// Sequencer states, Gray coded along idle, pointer, low, high.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_POINTER = 3'h1,
		ST_LOW_WORD = 3'h3,
		ST_HIGH_WORD = 3'h2,
		ST_BITS = 3'h6
	} alu_state_t;
endpackage

// *** rtl/alu_core.sv ***
/*
 * Accumulator load unit: carries out the double-word, bit-field, octal
 * address and indexed word loads into a 32-bit accumulator backed by an
 * eight-level push-down stack, and keeps the zero-result flag.
 * Assumes the sequencer offers an operation only while busy is low, and
 * that each memory raises its acknowledge with read data for one cycle.
 */
`timescale 1ns/1ps

// Contract
// [RULE1] Double-word load writes full 32 bits.
// [RULE2] Source: two words, immediate, or pointer.
// [RULE3] Zero flag follows every loaded value.
// [RULE4] Consecutive loads push old accumulator first.
// [RULE5] Bit-field load copies 1 to 32 bits.
// [RULE6] Bits beyond the count are zero.
// [RULE7] Octal operand converted to binary, 16 bits.
// [RULE8] Indexed address is source plus stack top.
// [RULE9] Indexed word fills low half, upper cleared.
// [RULE10] Eight-level stack, deepest entry is lost.
// [RULE11] Accumulator cleared at each scan end.
// [RULE12] 32-bit transfers use two adjacent words.
// [RULE13] Store cancels the pending push.
// [RULE14] Lower word fills bits 15 to 0.
// [RULE15] Start bit lands in bit 0, ascending.
module alu_core (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic op_valid_in,
	input wire alu_pkg::alu_op_t op_code_in,
	input wire alu_pkg::alu_src_t op_src_in,
	input wire logic [alu_pkg::ADDR_W-1:0] op_addr_in,
	input wire logic [alu_pkg::ACC_W-1:0] op_imm_in,
	input wire logic [alu_pkg::CNT_W-1:0] op_count_in,
	input wire logic store_in,
	input wire logic scan_end_in,
	input wire logic word_ack_in,
	input wire logic [alu_pkg::WORD_W-1:0] word_data_in,
	input wire logic bit_ack_in,
	input wire logic bit_data_in,
	output logic word_rd_out,
	output logic [alu_pkg::ADDR_W-1:0] word_addr_out,
	output logic bit_rd_out,
	output logic [alu_pkg::ADDR_W-1:0] bit_addr_out,
	output logic [alu_pkg::ACC_W-1:0] acc_out,
	output logic [alu_pkg::ACC_W-1:0] stack_top_out,
	output logic zero_result_flag_out,
	output logic busy_out,
	output logic done_out
);
	import alu_pkg::*;

	// Turns octal digits held one per nibble into their binary value.
	// Only the low three bits of each nibble are used, so a digit of 8 or
	// 9 silently folds; the sequencer is trusted to pass octal digits.
	function automatic logic [WORD_W-1:0] oct_to_bin(
		input logic [ACC_W-1:0] digits
	);
		logic [3*OCT_DIGITS-1:0] packed_bits;
		packed_bits = '0;
		for (int i = 0; i < OCT_DIGITS; i++) begin
			packed_bits[3*i +: 3] = digits[4*i +: 3];
		end
		return packed_bits[WORD_W-1:0];
	endfunction

	// Clamps the requested bit count into the legal range of 1 to 32.
	function automatic logic [CNT_W-1:0] clamp_count(
		input logic [CNT_W-1:0] count
	);
		return (count == CNT_RST) ? CNT_STEP :
			((count > MAX_BITS) ? MAX_BITS : count);
	endfunction

	alu_state_t state_r, state_nxt;              // Sequencer state.
	logic [ACC_W-1:0] acc_r, acc_nxt;            // The accumulator.
	logic [ACC_W-1:0] stack_r [STACK_DEPTH];     // Stack, level 0 on top.
	logic [ACC_W-1:0] stack_nxt [STACK_DEPTH];   // Next stack contents.
	logic zero_r, zero_nxt;                      // Zero-result flag.
	logic push_pend_r, push_pend_nxt;            // A load happened since store or scan end.
	logic done_r, done_nxt;                      // Load completed pulse.
	logic busy_r, busy_nxt;                      // Multi-cycle load running.
	logic word_rd_r, word_rd_nxt;                // Word read request.
	logic [ADDR_W-1:0] word_addr_r, word_addr_nxt;
	logic bit_rd_r, bit_rd_nxt;                  // Bit read request.
	logic [ADDR_W-1:0] bit_addr_r, bit_addr_nxt;
	logic [ACC_W-1:0] build_r, build_nxt;        // Value being assembled.
	logic [CNT_W-1:0] bit_idx_r, bit_idx_nxt;    // Bits gathered so far.
	logic [CNT_W-1:0] bit_len_r, bit_len_nxt;    // Bits wanted in total.
	logic is_double_r, is_double_nxt;            // Word sequence is a double.
	logic do_commit;                             // Write a value this cycle.
	logic [ACC_W-1:0] commit_val;                // The value to be written.

	// Sequencer: fetches operands, assembles the value and commits it.
	always_comb begin
		state_nxt = state_r;
		acc_nxt = acc_r;
		zero_nxt = zero_r;
		push_pend_nxt = push_pend_r;
		done_nxt = 1'b0;
		busy_nxt = busy_r;
		word_rd_nxt = word_rd_r;
		word_addr_nxt = word_addr_r;
		bit_rd_nxt = bit_rd_r;
		bit_addr_nxt = bit_addr_r;
		build_nxt = build_r;
		bit_idx_nxt = bit_idx_r;
		bit_len_nxt = bit_len_r;
		is_double_nxt = is_double_r;
		do_commit = 1'b0;
		commit_val = ACC_RST;
		for (int i = 0; i < STACK_DEPTH; i++) begin
			stack_nxt[i] = stack_r[i];
		end
		case (state_r)
			ST_IDLE: begin
				// A new operation is taken only here; busy keeps others off.
				if (op_valid_in) begin
					build_nxt = ACC_RST;
					is_double_nxt = (op_code_in == OP_DOUBLE_WORD_LOAD);
					case (op_code_in)
						OP_DOUBLE_WORD_LOAD: begin
							if (op_src_in == SRC_IMMEDIATE) begin
								do_commit = 1'b1;  // [RULE1] [RULE2]
								commit_val = op_imm_in;
							end else begin
								// Direct words or a pointer word first. [RULE2]
								word_rd_nxt = 1'b1;
								word_addr_nxt = op_addr_in;
								busy_nxt = 1'b1;
								state_nxt = (op_src_in == SRC_POINTER) ?
									ST_POINTER : ST_LOW_WORD;
							end
						end
						OP_BIT_FIELD_LOAD: begin
							bit_rd_nxt = 1'b1;
							bit_addr_nxt = op_addr_in;
							bit_idx_nxt = CNT_RST;
							bit_len_nxt = clamp_count(op_count_in);  // [RULE5]
							busy_nxt = 1'b1;
							state_nxt = ST_BITS;
						end
						OP_OCTAL_ADDRESS_LOAD: begin
							do_commit = 1'b1;
							commit_val = {16'h0000, oct_to_bin(op_imm_in)};  // [RULE7]
						end
						OP_INDEXED_WORD_LOAD: begin
							// Offset: stack top once this load has pushed. [RULE8]
							word_rd_nxt = 1'b1;
							word_addr_nxt = op_addr_in + (push_pend_r ?
								acc_r[ADDR_W-1:0] : stack_r[0][ADDR_W-1:0]);
							busy_nxt = 1'b1;
							state_nxt = ST_LOW_WORD;
						end
						default: build_nxt = build_r;  // Unknown codes are ignored.
					endcase
				end
			end
			ST_POINTER: begin
				// The pointer word holds the binary address of the data.
				if (word_ack_in) begin
					word_addr_nxt = word_data_in;
					state_nxt = ST_LOW_WORD;
				end
			end
			ST_LOW_WORD: begin
				if (word_ack_in) begin
					build_nxt = {16'h0000, word_data_in};  // [RULE14]
					if (!is_double_r) begin
						// Indexed load ends here, upper half zero. [RULE9]
						do_commit = 1'b1;
						commit_val = {16'h0000, word_data_in};
						word_rd_nxt = 1'b0;
						busy_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end else begin
						// Second, adjacent location for the upper half. [RULE12]
						word_addr_nxt = word_addr_r + ADDR_STEP;
						state_nxt = ST_HIGH_WORD;
					end
				end
			end
			ST_HIGH_WORD: begin
				if (word_ack_in) begin
					do_commit = 1'b1;  // [RULE1]
					commit_val = {word_data_in, build_r[WORD_W-1:0]};  // [RULE14]
					word_rd_nxt = 1'b0;
					busy_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			ST_BITS: begin
				if (bit_ack_in) begin
					// Bit n of the field lands in accumulator bit n. [RULE15]
					build_nxt = build_r |
						(ACC_W'(bit_data_in) << bit_idx_r[4:0]);
					bit_idx_nxt = bit_idx_r + CNT_STEP;
					bit_addr_nxt = bit_addr_r + ADDR_STEP;
					if (bit_idx_nxt == bit_len_r) begin
						// Build started at zero, so upper bits stay zero. [RULE6]
						do_commit = 1'b1;
						commit_val = build_nxt;
						bit_rd_nxt = 1'b0;
						busy_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				busy_nxt = 1'b0;
				word_rd_nxt = 1'b0;
				bit_rd_nxt = 1'b0;
			end
		endcase
		// A store cancels the push; a commit in the same cycle sets it again,
		// so a load that lands with a store still pushes and leaves a push pending.
		if (store_in) begin
			push_pend_nxt = 1'b0;  // [RULE13]
		end
		// Writing a value: push first if a load came before, no store or scan end since.
		if (do_commit) begin
			if (push_pend_r) begin
				stack_nxt[0] = acc_r;  // [RULE4]
				for (int i = 1; i < STACK_DEPTH; i++) begin
					stack_nxt[i] = stack_r[i-1];  // [RULE10]
				end
			end
			acc_nxt = commit_val;
			zero_nxt = (commit_val == ACC_RST);  // [RULE3]
			push_pend_nxt = 1'b1;
			done_nxt = 1'b1;
		end
		// End of scan wins over anything else on the accumulator.
		if (scan_end_in) begin
			acc_nxt = ACC_RST;  // [RULE11]
			push_pend_nxt = 1'b0;
		end
	end

	// Registers of the sequencer and the accumulator.
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= ST_IDLE;
			acc_r <= ACC_RST;
			zero_r <= 1'b0;
			push_pend_r <= 1'b0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
			word_rd_r <= 1'b0;
			word_addr_r <= ADDR_RST;
			bit_rd_r <= 1'b0;
			bit_addr_r <= ADDR_RST;
			build_r <= ACC_RST;
			bit_idx_r <= CNT_RST;
			bit_len_r <= CNT_RST;
			is_double_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			acc_r <= acc_nxt;
			zero_r <= zero_nxt;
			push_pend_r <= push_pend_nxt;
			done_r <= done_nxt;
			busy_r <= busy_nxt;
			word_rd_r <= word_rd_nxt;
			word_addr_r <= word_addr_nxt;
			bit_rd_r <= bit_rd_nxt;
			bit_addr_r <= bit_addr_nxt;
			build_r <= build_nxt;
			bit_idx_r <= bit_idx_nxt;
			bit_len_r <= bit_len_nxt;
			is_double_r <= is_double_nxt;
		end
	end

	// Stack levels, each one register stage per level.
	generate
		for (genvar g = 0; g < STACK_DEPTH; g++) begin : g_level
			always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					stack_r[g] <= ACC_RST;
				end else begin
					stack_r[g] <= stack_nxt[g];
				end
			end
		end
	endgenerate

	// Every output is a flip-flop.
	assign word_rd_out = word_rd_r;
	assign word_addr_out = word_addr_r;
	assign bit_rd_out = bit_rd_r;
	assign bit_addr_out = bit_addr_r;
	assign acc_out = acc_r;
	assign stack_top_out = stack_r[0];
	assign zero_result_flag_out = zero_r;
	assign busy_out = busy_r;
	assign done_out = done_r;
endmodule // alu_core

// *** rtl/alu_core_fix_note.sv ***
/*
 * Holds no logic: the whole load unit lives in alu_core.
 * Assumes nothing of its surroundings.
 */
`timescale 1ns/1ps

// *** verif/alu_core_props.sv ***
/* Assertion checker for the accumulator load unit.
   Assumes it is bound to alu_core and watches only its ports. */
`timescale 1ns/1ps
module alu_core_props (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic scan_end_in,
	input wire logic word_ack_in,
	input wire logic bit_ack_in,
	input wire logic word_rd_out,
	input wire logic [alu_pkg::ADDR_W-1:0] word_addr_out,
	input wire logic bit_rd_out,
	input wire logic [alu_pkg::ADDR_W-1:0] bit_addr_out,
	input wire logic [alu_pkg::ACC_W-1:0] acc_out,
	input wire logic [alu_pkg::ACC_W-1:0] stack_top_out,
	input wire logic zero_result_flag_out,
	input wire logic busy_out,
	input wire logic done_out
);
	import alu_pkg::*;
	// All checks share the one clock and its reset.
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	property p_done_busy; done_out |-> !busy_out; endproperty
	a_done_busy: assert property (p_done_busy)
		else $error("busy still high in commit cycle");
	// Scan end clears the value but leaves the flag, so skip that cycle.
	property p_zero;
		done_out && !$past(scan_end_in) |->
			zero_result_flag_out == (acc_out == ACC_RST);
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag does not match loaded value");
	property p_push;
		done_out && stack_top_out != $past(stack_top_out) |->
			stack_top_out == $past(acc_out);
	endproperty
	a_push: assert property (p_push)
		else $error("pushed value is not the old accumulator");
	property p_acc_stable;
		!done_out && !$past(scan_end_in) |-> $stable(acc_out);
	endproperty
	a_acc_stable: assert property (p_acc_stable)
		else $error("accumulator changed without a commit");
	property p_stack_stable; !done_out |-> $stable(stack_top_out); endproperty
	a_stack_stable: assert property (p_stack_stable)
		else $error("stack moved without a commit");
	property p_word_hold;
		word_rd_out && !word_ack_in |=> word_rd_out && $stable(word_addr_out);
	endproperty
	a_word_hold: assert property (p_word_hold)
		else $error("word request dropped before its answer");
	property p_bit_next;
		bit_rd_out && bit_ack_in |=>
			!bit_rd_out || bit_addr_out == $past(bit_addr_out) + ADDR_STEP;
	endproperty
	a_bit_next: assert property (p_bit_next)
		else $error("bit address did not step by one");
	property p_scan_clear; scan_end_in |=> acc_out == ACC_RST; endproperty
	a_scan_clear: assert property (p_scan_clear)
		else $error("accumulator not cleared after scan end");
	property p_idle; !busy_out |-> !word_rd_out && !bit_rd_out; endproperty
	a_idle: assert property (p_idle)
		else $error("memory request while idle");
endmodule // alu_core_props
bind alu_core alu_core_props alu_core_props_inst (.*);

// *** verif/alu_mem_model.sv ***
/* Word and bit data memory facing the load unit.
   Word at address a holds ~a, bit at a holds a[1]^a[2]; lat_in sets
   how many idle cycles pass before each acknowledge. */
`timescale 1ns/1ps
module alu_mem_model (
	input wire logic clk_sys_in,
	input wire logic [1:0] lat_in,
	input wire logic word_rd_in,
	input wire logic [15:0] word_addr_in,
	output logic word_ack_out,
	output logic [15:0] word_data_out,
	input wire logic bit_rd_in,
	input wire logic [15:0] bit_addr_in,
	output logic bit_ack_out,
	output logic bit_data_out
);
	logic [1:0] wc_r = 2'h0, bc_r = 2'h0; // Wait counters.
	initial begin
		word_ack_out = 1'b0;
		bit_ack_out = 1'b0;
		word_data_out = 16'h0;
		bit_data_out = 1'b0;
	end
	// Data toggles outside an answer so a stale read never passes.
	always @(posedge clk_sys_in) begin
		word_ack_out <= 1'b0;
		bit_ack_out <= 1'b0;
		word_data_out <= ~word_data_out;
		bit_data_out <= ~bit_data_out;
		if (word_rd_in && !word_ack_out) begin
			wc_r <= (wc_r == lat_in) ? 2'h0 : wc_r + 2'h1;
			if (wc_r == lat_in) begin
				word_ack_out <= 1'b1;
				word_data_out <= ~word_addr_in;
			end
		end
		if (bit_rd_in && !bit_ack_out) begin
			bc_r <= (bc_r == lat_in) ? 2'h0 : bc_r + 2'h1;
			if (bc_r == lat_in) begin
				bit_ack_out <= 1'b1;
				bit_data_out <= bit_addr_in[1] ^ bit_addr_in[2];
			end
		end
	end
endmodule // alu_mem_model

// *** verif/alu_core_tb_top.sv ***
/* Self-checking bench for the accumulator load unit.
   Assumes alu_core with its checker bound and the memory model. */
`timescale 1ns/1ps
module alu_core_tb_top;
	import alu_pkg::*;
	logic clk_sys_in, rst_b_in, op_valid_in, store_in, scan_end_in;
	alu_op_t op_code_in;
	alu_src_t op_src_in;
	logic [15:0] op_addr_in, word_data_in, word_addr_out, bit_addr_out;
	logic [31:0] op_imm_in, acc_out, stack_top_out;
	logic [5:0] op_count_in;
	logic word_ack_in, bit_ack_in, bit_data_in, word_rd_out, bit_rd_out;
	logic zero_result_flag_out, busy_out, done_out;
	logic [1:0] lat;
	int num_errors = 0, n_tests = 0, cyc = 0;
	alu_core alu_core_inst (.*);
	alu_mem_model alu_mem_model_inst (.clk_sys_in, .lat_in(lat),
		.word_rd_in(word_rd_out), .word_addr_in(word_addr_out),
		.word_ack_out(word_ack_in), .word_data_out(word_data_in),
		.bit_rd_in(bit_rd_out), .bit_addr_in(bit_addr_out),
		.bit_ack_out(bit_ack_in), .bit_data_out(bit_data_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end
	task end_sim;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// A hung handshake must still reach the report.
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			end_sim();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task tick;
		@(posedge clk_sys_in);
		#1;
	endtask
	// Offers one operation, then waits for its commit pulse.
	task automatic run_op(alu_op_t c, alu_src_t s, logic [15:0] a,
		logic [31:0] i, logic [5:0] n);
		int k = 0;
		op_code_in = c;
		op_src_in = s;
		op_addr_in = a;
		op_imm_in = i;
		op_count_in = n;
		op_valid_in = 1'b1;
		tick();
		op_valid_in = 1'b0;
		while (done_out !== 1'b1 && k < 300) begin
			tick();
			k++;
		end
		chk(32'(done_out), 32'h1);
	endtask
	task automatic t_push_store;
		logic [31:0] s;
		scan_end_in = 1'b1;
		tick();
		scan_end_in = 1'b0;
		s = stack_top_out;
		run_op(OP_DOUBLE_WORD_LOAD, SRC_IMMEDIATE, 16'h0, 32'hFFFFFFFF, 6'h0);
		chk(stack_top_out, s);
		chk(32'(zero_result_flag_out), 32'h0);
		run_op(OP_DOUBLE_WORD_LOAD, SRC_IMMEDIATE, 16'h0, 32'h0, 6'h0);
		chk(32'(zero_result_flag_out), 32'h1);
		chk(stack_top_out, 32'hFFFFFFFF);
		store_in = 1'b1;
		tick();
		store_in = 1'b0;
		run_op(OP_DOUBLE_WORD_LOAD, SRC_IMMEDIATE, 16'h0, 32'h3, 6'h0);
		chk(stack_top_out, 32'hFFFFFFFF);
		for (int i = 1; i < 10; i++) begin
			s = acc_out;
			run_op(OP_DOUBLE_WORD_LOAD, SRC_IMMEDIATE, 16'h0, i, 6'h0);
			chk(stack_top_out, s);
		end
	endtask
	task automatic t_double;
		logic [15:0] a;
		for (int l = 0; l < 3; l++) begin
			lat = l[1:0];
			a = 16'h1230 + l[15:0];
			run_op(OP_DOUBLE_WORD_LOAD, SRC_DIRECT, a, 32'h0, 6'h0);
			chk(acc_out, {~(a + 16'h1), ~a});
		end
		run_op(OP_DOUBLE_WORD_LOAD, SRC_POINTER, 16'hF000, 32'h0, 6'h0);
		chk(acc_out, 32'hEFFFF000);
	endtask
	task automatic t_bits;
		logic [5:0] n [5] = '{6'h01, 6'h07, 6'h20, 6'h00, 6'h28};
		logic [31:0] e;
		logic [15:0] a;
		int m;
		lat = 2'h1;
		for (int j = 0; j < 5; j++) begin
			m = (n[j] == 6'h0) ? 1 : (n[j] > 6'h20) ? 32 : int'(n[j]);
			e = 32'h0;
			for (int k = 0; k < m; k++) begin
				a = 16'h0010 + k[15:0];
				e[k] = a[1] ^ a[2];
			end
			run_op(OP_BIT_FIELD_LOAD, SRC_DIRECT, 16'h0010, 32'h0, n[j]);
			chk(acc_out, e);
		end
	endtask
	task t_octal_index;
		run_op(OP_OCTAL_ADDRESS_LOAD, SRC_DIRECT, 16'h0, 32'h00040400, 6'h0);
		chk(acc_out, 32'h4100);
		run_op(OP_OCTAL_ADDRESS_LOAD, SRC_DIRECT, 16'h0, 32'h25, 6'h0);
		chk(acc_out, 32'h15);
		run_op(OP_DOUBLE_WORD_LOAD, SRC_IMMEDIATE, 16'h0, 32'hABCD, 6'h0);
		run_op(OP_INDEXED_WORD_LOAD, SRC_DIRECT, 16'h0308, 32'h0, 6'h0);
		chk(acc_out, 32'h0000512A);
		chk(stack_top_out, 32'h0000ABCD);
		scan_end_in = 1'b1;
		tick();
		scan_end_in = 1'b0;
		chk(acc_out, 32'h0);
	endtask
	// Mid-run reset clears the stack, and the next load pushes nothing.
	task t_reset;
		rst_b_in = 1'b0;
		tick();
		chk(stack_top_out, 32'h0);
		chk(32'(zero_result_flag_out), 32'h0);
		rst_b_in = 1'b1;
		run_op(OP_DOUBLE_WORD_LOAD, SRC_IMMEDIATE, 16'h0, 32'h5, 6'h0);
		chk(stack_top_out, 32'h0);
	endtask
	initial begin
		rst_b_in = 1'b0;
		op_valid_in = 1'b0;
		store_in = 1'b0;
		scan_end_in = 1'b0;
		op_code_in = OP_NONE;
		op_src_in = SRC_DIRECT;
		op_addr_in = 16'h0;
		op_imm_in = 32'h0;
		op_count_in = 6'h0;
		lat = 2'h0;
		repeat (10) @(posedge clk_sys_in);
		#1 rst_b_in = 1'b1;
		t_push_store();
		t_double();
		t_bits();
		t_octal_index();
		t_reset();
		end_sim();
	end
endmodule // alu_core_tb_top
